// File: sleep_wake_power_controller_bench.sv
`timescale 1ns/1ps
module sleep_wake_power_controller_bench;
  logic                   sys_clk, rst, pbtn, ac_ok, standby_ok, fire, e;
  logic [3:0]             cmd, tach;
  logic [2:0]             sel;
  swp_pkg::swp_cfg_type   cfg;
  swp_pkg::swp_wake_type  src;
  swp_pkg::swp_state_type state;
  swp_pkg::swp_state_type slp [4];
  wire                    supply_en, standby_led, led_green, led_amber, pend;
  wire [3:0]              tach_mon, fan_en;
  int                     seed, n_errors, checked, cyc;

  swp_far_model far (.fire(fire), .sel(sel), .src(src));
  swp_power_ctrl #(.NUM_FANS(4)) dut (.sys_clk(sys_clk), .rst(rst),
    .cfg(cfg), .sleep_s1_req(cmd[0]), .sleep_s3_req(cmd[1]),
    .sleep_s4_req(cmd[2]), .power_off_req(cmd[3]), .power_btn(pbtn),
    .ac_ok(ac_ok), .standby_ok(standby_ok), .supply_en(supply_en),
    .standby_led(standby_led), .led_green(led_green),
    .led_amber(led_amber), .wake_src(src), .wake_pending(pend),
    .fan_tach(tach), .fan_tach_mon(tach_mon), .fan_pwr_en(fan_en),
    .state(state));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Expected wake outcome for a source index in a sleep state
  function automatic logic exp_wake(swp_pkg::swp_state_type s, int k,
                                    swp_pkg::swp_cfg_type c);
    logic s13, s5;
    s13 = (s == swp_pkg::SWP_S1) || (s == swp_pkg::SWP_S3);
    s5 = (s == swp_pkg::SWP_S5);
    case (k)
      0: return !s5 || c.s5_net_en;
      1, 2: return s13 && c.modem_irq_unmasked;
      3, 4: return s13;
      5: return c.pme_wake_en && (!s5 || c.s5_pme_en);
      default: return 1'b1;
    endcase
  endfunction

  task automatic chk_st(input swp_pkg::swp_state_type x, input string what);
    checked++;
    if (state !== x) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, x, state);
    end
  endtask

  task automatic chk_bit(input logic x, input logic s, input string what);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", what, x, s);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Ceiling well above the roughly 330 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    seed = 92;
    slp = '{swp_pkg::SWP_S1, swp_pkg::SWP_S3, swp_pkg::SWP_S4,
            swp_pkg::SWP_S5};
    rst = 1'b1; pbtn = 1'b0; ac_ok = 1'b1; standby_ok = 1'b1;
    fire = 1'b0; sel = 3'h0; cmd = 4'h0; tach = 4'h0; cfg = 7'h00;
    cfg.restore_mode = swp_pkg::SWP_RST_ON;
    ticks(12);
    rst = 1'b0;
    ticks(3);
    chk_st(swp_pkg::SWP_S0, "state after ac");
    chk_bit(1'b1, led_green, "led_green");
    chk_bit(1'b1, standby_led, "standby_led");
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 7; k++) begin
        // Interrupt mask drawn at random with the rest
        cfg = swp_pkg::swp_cfg_type'(7'($random(seed)));
        cfg.restore_mode = swp_pkg::SWP_RST_LAST;
        tach = 4'($random(seed));
        cmd = 4'h1 << i;
        ticks(1);
        chk_bit(1'b1, tach_mon === tach, "fan_tach_mon");
        cmd = 4'h0;
        ticks(2);
        chk_st(slp[i], "sleep state");
        chk_bit(i == 0, fan_en[0], "fan_pwr_en");
        chk_bit(i == 0, supply_en, "supply_en");
        chk_bit(i == 1 && cfg.led_dual_colour, led_amber, "amber");
        e = exp_wake(slp[i], k, cfg);
        fire = 1'b1;
        sel = 3'(k);
        ticks(1);
        chk_bit(e, pend, "wake_pending");
        ticks(1);
        fire = 1'b0;
        ticks(4);
        chk_st(e ? swp_pkg::SWP_S0 : slp[i], "wake result");
        chk_bit(1'b0, pend, "wake_pending idle");
        if (!e) begin
          pbtn = 1'b1;
          ticks(1);
          pbtn = 1'b0;
          ticks(3);
        end
      end
    end
    // Outage from on, then from soft off, with last-state policy
    ac_ok = 1'b0;
    ticks(3);
    chk_st(swp_pkg::SWP_OFF, "outage");
    ac_ok = 1'b1;
    ticks(3);
    chk_st(swp_pkg::SWP_S0, "return on");
    cmd = 4'h8;
    ticks(1);
    cmd = 4'h0;
    ac_ok = 1'b0;
    ticks(3);
    ac_ok = 1'b1;
    ticks(3);
    chk_st(swp_pkg::SWP_S5, "return off");
    end_of_test();
  end
endmodule // sleep_wake_power_controller_bench

// File: swp_far_model.sv
`timescale 1ns/1ps
module swp_far_model (
  // Command from the bench
  input  wire                   fire,
  input  wire [2:0]             sel,
  // Wake lines toward the controller
  output swp_pkg::swp_wake_type src
);
  // One source at a time
  // Ring lines are driven apart so both modem paths get exercised
  assign src = fire ? swp_pkg::swp_wake_type'(7'h40 >> sel) : 7'h00;
endmodule // swp_far_model

// File: swp_pkg.sv
// Overview of operation
// - Fan power stays on in working state S0 and sleep state S1.
// - Fan power is off when off or in S3, S4 or S5.
// - Every fan channel passes its tachometer to monitoring; speed or on/off.
// - A power-off command drops supply enable; standby power stays.
// - After AC returns, restore the on or off state held before.
// - Restore behaviour is chosen by a firmware last-state setting.
// - In S3 supply is off; indicator amber if dual colour, else off.
// - Enabled wake in S3 restores power and returns to working state.
// - Modem ring wakes only from S1 or S3.
// - External and internal modem rings share one wake path.
// - USB activity wakes only from S1 or S3.
// - PS/2 activity wakes only from S1 or S3.
// - PCI PME wakes from S1, S3, S4, S5 only with its enable on.
// - PCI Express wake wakes from S1, S3, S4 or S5 unconditionally.
// - Standby indicator is lit whenever standby power is present.
// - Wake from S5 by network or PME needs its firmware option set.
package swp_pkg;

  // System power states, one-hot
  typedef enum logic [5:0] {
    SWP_S0  = 6'h01,
    SWP_S1  = 6'h02,
    SWP_S3  = 6'h04,
    SWP_S4  = 6'h08,
    SWP_S5  = 6'h10,
    SWP_OFF = 6'h20
  } swp_state_type;

  // Last-state restore policy after AC outage
  typedef enum logic [1:0] {
    SWP_RST_OFF  = 2'h0,
    SWP_RST_ON   = 2'h1,
    SWP_RST_LAST = 2'h2
  } swp_restore_type;

  // Raw wake sources, active high after board inversion
  typedef struct packed {
    logic net;
    logic ring_ext;
    logic ring_int;
    logic usb;
    logic ps2;
    logic pme;
    logic pcie_wake;
  } swp_wake_type;

  // Firmware settings
  typedef struct packed {
    swp_restore_type restore_mode;
    logic            pme_wake_en;
    logic            s5_net_en;
    logic            s5_pme_en;
    logic            modem_irq_unmasked;
    logic            led_dual_colour;
  } swp_cfg_type;

  localparam logic       SWP_CFG_S5_DEFAULT = 1'b0;
  localparam int         SWP_DEF_FANS       = 4;

endpackage

// File: swp_power_ctrl.sv
`timescale 1ns/1ps
module swp_power_ctrl #(
  parameter int NUM_FANS = swp_pkg::SWP_DEF_FANS
) (
  // Clock and reset
  input  wire                         sys_clk,
  input  wire                         rst,
  // Firmware settings
  input  wire swp_pkg::swp_cfg_type   cfg,
  // OS sleep commands
  input  wire                         sleep_s1_req,
  input  wire                         sleep_s3_req,
  input  wire                         sleep_s4_req,
  input  wire                         power_off_req,
  input  wire                         power_btn,
  // Power supply
  input  wire                         ac_ok,
  input  wire                         standby_ok,
  output logic                        supply_en,
  output logic                        standby_led,
  output logic                        led_green,
  output logic                        led_amber,
  // Wake sources
  input  wire swp_pkg::swp_wake_type  wake_src,
  output logic                        wake_pending,
  // Fans
  input  wire [NUM_FANS-1:0]          fan_tach,
  output logic [NUM_FANS-1:0]         fan_tach_mon,
  output logic [NUM_FANS-1:0]         fan_pwr_en,
  // Status
  output swp_pkg::swp_state_type      state
);
  swp_pkg::swp_state_type st_q, st_d;
  logic                   was_on_q, was_on_d;
  logic                   ac_q;
  logic                   wake_q, wake_d;
  logic                   wake_any;
  logic [NUM_FANS-1:0]    tach_q;

  swp_wake_merge u_merge (
    .st       (st_q),
    .cfg      (cfg),
    .src      (wake_src),
    .wake_any (wake_any)
  );

  wire ac_rise  = ac_ok & ~ac_q;
  wire ac_fall  = ~ac_ok & ac_q;
  wire asleep   = (st_q != swp_pkg::SWP_S0);
  // Power-up begins when the request or button leaves a sleep state
  wire power_up = asleep & ac_ok & (wake_q | power_btn);
  wire restore_on = (cfg.restore_mode == swp_pkg::SWP_RST_ON) |
                    ((cfg.restore_mode == swp_pkg::SWP_RST_LAST) & was_on_q);

  // Latched wake request; set wins, cleared at power-up
  // Dropped once awake too, so a stale request never bounces the next sleep
  assign wake_d = wake_any | (wake_q & asleep & ~power_up);

  always_comb begin
    st_d     = st_q;
    was_on_d = was_on_q;
    case (st_q)
      swp_pkg::SWP_S0: begin
        if (power_off_req) begin
          st_d     = swp_pkg::SWP_S5;
          was_on_d = 1'b0;
        end else if (sleep_s1_req) begin
          st_d = swp_pkg::SWP_S1;
        end else if (sleep_s3_req) begin
          st_d = swp_pkg::SWP_S3;
        end else if (sleep_s4_req) begin
          st_d = swp_pkg::SWP_S4;
        end
      end
      swp_pkg::SWP_S1, swp_pkg::SWP_S3, swp_pkg::SWP_S4,
      swp_pkg::SWP_S5: begin
        if (power_up) begin
          st_d     = swp_pkg::SWP_S0;
          was_on_d = 1'b1;
        end
      end
      swp_pkg::SWP_OFF: begin
        if (ac_rise) begin
          st_d     = restore_on ? swp_pkg::SWP_S0 : swp_pkg::SWP_S5;
          was_on_d = restore_on;
        end
      end
      default: st_d = swp_pkg::SWP_OFF;
    endcase
    // Outage forces off; the last on/off memory and a latched wake request are kept
    if (ac_fall) begin
      st_d = swp_pkg::SWP_OFF;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q     <= swp_pkg::SWP_OFF;
      was_on_q <= 1'b0;
      ac_q     <= 1'b0;
      wake_q   <= 1'b0;
      tach_q   <= '0;
    end else begin
      st_q     <= st_d;
      was_on_q <= was_on_d;
      ac_q     <= ac_ok;
      wake_q   <= wake_d;
      tach_q   <= fan_tach;
    end
  end

  wire in_s0 = (st_q == swp_pkg::SWP_S0);
  wire in_s1 = (st_q == swp_pkg::SWP_S1);
  wire in_s3 = (st_q == swp_pkg::SWP_S3);
  wire in_s5 = (st_q == swp_pkg::SWP_S5);

  // Single-source patterns the gating checks look for
  localparam swp_pkg::swp_wake_type ONLY_NET = '{net: 1'b1, default: 1'b0};
  localparam swp_pkg::swp_wake_type ONLY_EXT =
    '{ring_ext: 1'b1, default: 1'b0};
  localparam swp_pkg::swp_wake_type ONLY_INT =
    '{ring_int: 1'b1, default: 1'b0};
  localparam swp_pkg::swp_wake_type ONLY_PS2 = '{ps2: 1'b1, default: 1'b0};
  localparam swp_pkg::swp_wake_type ONLY_PME = '{pme: 1'b1, default: 1'b0};
  wire ring_only = (wake_src == ONLY_EXT) | (wake_src == ONLY_INT);

  // Fans on in S0 or S1
  wire fans_on = in_s0 | in_s1;
  genvar g;
  generate
    for (g = 0; g < NUM_FANS; g++) begin : g_fan
      assign fan_pwr_en[g] = fans_on;
      assign fan_tach_mon[g] = tach_q[g];
    end
  endgenerate

  assign supply_en   = fans_on;
  assign standby_led = standby_ok;
  assign led_green   = in_s0 | in_s1;
  assign led_amber   = in_s3 & cfg.led_dual_colour;
  assign wake_pending = wake_q;
  assign state       = st_q;

  // Assertions
  fan_state_a: assert property (@(posedge sys_clk) disable iff (rst)
    fan_pwr_en[0] == (st_q == swp_pkg::SWP_S0 || st_q == swp_pkg::SWP_S1))
    else $error("fan power wrong for state");
  fan_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == swp_pkg::SWP_S3 || st_q == swp_pkg::SWP_S5) |-> !fan_pwr_en[0])
    else $error("fan on in deep sleep");
  tach_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
    fan_tach_mon == $past(fan_tach))
    else $error("tach not forwarded");
  soft_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    (in_s0 && power_off_req && ac_ok) |=> !supply_en && standby_led == standby_ok)
    else $error("power off not honoured");
  restore_last_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == swp_pkg::SWP_OFF && ac_rise && was_on_q &&
     cfg.restore_mode == swp_pkg::SWP_RST_LAST) |=> in_s0)
    else $error("last state not restored");
  restore_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == swp_pkg::SWP_OFF && ac_rise &&
     cfg.restore_mode == swp_pkg::SWP_RST_OFF) |=> !supply_en)
    else $error("restore mode ignored");
  s3_led_a: assert property (@(posedge sys_clk) disable iff (rst)
    in_s3 |-> !supply_en && led_amber == cfg.led_dual_colour)
    else $error("s3 indication wrong");
  s3_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
    (in_s3 && wake_q && ac_ok && !ac_fall) |=> in_s0 && supply_en)
    else $error("no wake from s3");
  usb_s4_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == swp_pkg::SWP_S4 && !wake_q && !power_btn && wake_src.usb
     && !wake_src.pcie_wake && !wake_src.pme && !wake_src.net)
    |=> !wake_q)
    else $error("usb woke from s4");
  pcie_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == swp_pkg::SWP_S4 && wake_src.pcie_wake && !ac_fall) |=> wake_q)
    else $error("pcie wake lost");
  standby_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_ok |-> standby_led)
    else $error("standby led dark");
  merge_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wake_q && asleep && !power_up) |=> wake_q)
    else $error("wake dropped early");
  pend_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    in_s0 |=> !wake_q)
    else $error("stale wake kept while on");
  deep_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == swp_pkg::SWP_OFF || st_q == swp_pkg::SWP_S4) |->
      fan_pwr_en == '0 && !supply_en)
    else $error("power on while off or in s4");
  s3_stay_a: assert property (@(posedge sys_clk) disable iff (rst)
    (in_s3 && !power_up && !ac_fall) |=> in_s3)
    else $error("s3 left without wake");
  ring_state_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wake_q && ring_only && !in_s1 && !in_s3) |=> !wake_q)
    else $error("ring woke from wrong state");
  ring_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((in_s1 || in_s3) && cfg.modem_irq_unmasked &&
     wake_src == ONLY_INT) |=> wake_q)
    else $error("internal ring lost");
  ring_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wake_q && ring_only && !cfg.modem_irq_unmasked) |=> !wake_q)
    else $error("masked ring woke");
  ps2_state_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wake_q && wake_src == ONLY_PS2 && !in_s1 && !in_s3) |=> !wake_q)
    else $error("ps2 woke from wrong state");
  pme_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wake_q && wake_src == ONLY_PME && !cfg.pme_wake_en) |=> !wake_q)
    else $error("pme woke while disabled");
  s5_net_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wake_q && in_s5 && wake_src == ONLY_NET && !cfg.s5_net_en)
    |=> !wake_q)
    else $error("network woke from s5");
  s5_pme_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wake_q && in_s5 && wake_src == ONLY_PME && !cfg.s5_pme_en)
    |=> !wake_q)
    else $error("pme woke from s5");
endmodule // swp_power_ctrl

// File: swp_wake_merge.sv
`timescale 1ns/1ps
module swp_wake_merge (
  // Current state and settings
  input  wire swp_pkg::swp_state_type st,
  input  wire swp_pkg::swp_cfg_type   cfg,
  // Sources
  input  wire swp_pkg::swp_wake_type  src,
  // Combined request
  output logic                        wake_any
);
  wire in_s1   = (st == swp_pkg::SWP_S1);
  wire in_s3   = (st == swp_pkg::SWP_S3);
  wire in_s4   = (st == swp_pkg::SWP_S4);
  wire in_s5   = (st == swp_pkg::SWP_S5);
  wire light   = in_s1 | in_s3;
  wire deep    = light | in_s4 | in_s5;
  wire no_s5   = light | in_s4;
  wire ring    = src.ring_ext | src.ring_int;
  wire w_ring  = ring & cfg.modem_irq_unmasked & light;
  wire w_usb   = src.usb & light;
  wire w_ps2   = src.ps2 & light;
  wire w_pme   = src.pme & cfg.pme_wake_en &
                 (no_s5 | (in_s5 & cfg.s5_pme_en));
  wire w_net   = src.net & (no_s5 | (in_s5 & cfg.s5_net_en));
  wire w_pcie  = src.pcie_wake & deep;
  assign wake_any = w_ring | w_usb | w_ps2 | w_pme | w_net | w_pcie;
endmodule // swp_wake_merge
